// *** rtl/inq_pkg.sv ***
// Constants and types for the standard identification responder
package inq_pkg;
  // Response geometry
  localparam int unsigned RESP_LEN  = 106;
  localparam logic [7:0]  RESP_LEN_B = 8'h6a;
  localparam logic [6:0]  LAST_IDX   = 7'h69;

  // Fixed header bytes
  localparam logic [2:0] QUAL_ATTACHED = 3'h0;
  localparam logic [4:0] TYPE_SEQ      = 5'h01;
  localparam logic [7:0] LUN_INVALID   = 8'h7f;
  localparam logic       REMOVABLE     = 1'b1;
  localparam logic [6:0] TYPE_MODIFIER = 7'h00;
  localparam logic [1:0] ISO_VER       = 2'h0;
  localparam logic [2:0] ECMA_VER      = 3'h0;
  localparam logic [2:0] ANSI_VER      = 3'h2;
  localparam logic [3:0] RESP_FMT      = 4'h2;
  localparam logic [7:0] ADD_LEN       = 8'h65;
  localparam logic [7:0] CAPS_VAL      = 8'h10;
  localparam logic [7:0] SPACE         = 8'h20;

  // Byte positions of the header and text fields
  localparam logic [6:0] IDX_B0    = 7'h00;
  localparam logic [6:0] IDX_B1    = 7'h01;
  localparam logic [6:0] IDX_B2    = 7'h02;
  localparam logic [6:0] IDX_B3    = 7'h03;
  localparam logic [6:0] IDX_B4    = 7'h04;
  localparam logic [6:0] IDX_B7    = 7'h07;
  localparam logic [6:0] VEND_LO   = 7'h08;
  localparam logic [6:0] VSPEC_LO  = 7'h24;
  localparam logic [6:0] RSV_LO    = 7'h38;
  localparam logic [6:0] SER_LO    = 7'h60;
  localparam logic [6:0] SER_SHIFT = 7'h30;

  // Identity storage: 15 words, text packed first character in lane 0
  localparam int unsigned CFG_WORDS = 15;
  localparam logic [31:0] CFG_RST   = 32'h20202020;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_CFG    = 8'h40;
  localparam logic       CTRL_RST    = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b10
  } state_t;
endpackage

// *** rtl/cfg_if.sv ***
`timescale 1ns/1ns
// Carrier between the responder core and its byte lookup
interface cfg_if;
  logic [31:0] words [inq_pkg::CFG_WORDS];
  logic        custom_en;
  logic        lun_bad;
  logic [6:0]  index;
  logic [7:0]  data;

  modport drive  (output words, custom_en, lun_bad, index, input data);
  modport lookup (input words, custom_en, lun_bad, index, output data);
endinterface // cfg_if

// *** rtl/inq_byte_table.sv ***
`timescale 1ns/1ns
// Indexed lookup of one response byte from fixed values and storage
module inq_byte_table (
  // Index in, byte out, storage contents
  cfg_if.lookup tbl
);
  logic [6:0]  rel;
  logic [3:0]  widx;
  logic [31:0] word;
  logic [7:0]  lane;

  // Storage word and lane for the text fields; reserved gap is skipped
  always_comb begin
    if (tbl.index < inq_pkg::RSV_LO) begin
      rel = 7'(tbl.index - inq_pkg::VEND_LO);
    end else begin
      rel = 7'(tbl.index - inq_pkg::SER_SHIFT);
    end
    widx = rel[5:2];
    word = (widx < 4'(inq_pkg::CFG_WORDS)) ? tbl.words[widx] : '0;
    lane = word[{rel[1:0], 3'b000} +: 8];
  end

  // Byte selection by position
  always_comb begin
    if (tbl.index == inq_pkg::IDX_B0) begin
      tbl.data = tbl.lun_bad ? inq_pkg::LUN_INVALID
               : {inq_pkg::QUAL_ATTACHED, inq_pkg::TYPE_SEQ};
    end else if (tbl.index == inq_pkg::IDX_B1) begin
      tbl.data = {inq_pkg::REMOVABLE, inq_pkg::TYPE_MODIFIER};
    end else if (tbl.index == inq_pkg::IDX_B2) begin
      tbl.data = {inq_pkg::ISO_VER, inq_pkg::ECMA_VER,
                  inq_pkg::ANSI_VER};
    end else if (tbl.index == inq_pkg::IDX_B3) begin
      tbl.data = {4'h0, inq_pkg::RESP_FMT};
    end else if (tbl.index == inq_pkg::IDX_B4) begin
      tbl.data = inq_pkg::ADD_LEN;
    end else if (tbl.index == inq_pkg::IDX_B7) begin
      tbl.data = inq_pkg::CAPS_VAL;
    end else if (tbl.index >= inq_pkg::VEND_LO &&
                 tbl.index < inq_pkg::VSPEC_LO) begin
      tbl.data = lane;
    end else if (tbl.index >= inq_pkg::VSPEC_LO &&
                 tbl.index < inq_pkg::RSV_LO) begin
      tbl.data = tbl.custom_en ? lane : inq_pkg::SPACE;
    end else if (tbl.index >= inq_pkg::SER_LO &&
                 tbl.index <= inq_pkg::LAST_IDX) begin
      // Unwritten serial characters pad out as blanks
      tbl.data = (lane == 8'h00) ? inq_pkg::SPACE : lane;
    end else begin
      tbl.data = 8'h00;
    end
  end
endmodule // inq_byte_table

// *** rtl/inq_responder.sv ***
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Standard identification responder: sequencer, registers, AXI-Lite
// Summary of operation
// - Standard response sent when vital select clear
// - Valid unit: qualifier bits read zero
// - Valid unit: device type reads 01h
// - Nonzero unit number: byte 0 is 7Fh
// - Byte 1 bit 7 set, removable
// - Byte 1 low bits read 00h
// - Byte 2 versions ISO 0, ECMA 0, ANSI 2
// - Byte 3: no events, no terminate, format 2h
// - Byte 4 reports 65h further bytes
// - Byte 7 only synchronous bit set
// - Bytes 8-15 manufacturer text, trailing space
// - Bytes 16-31 product name and configuration
// - Bytes 32-35 four character firmware revision
// - Bytes 36-55 blanks unless customer string enabled
// - Bytes 96-105 serial, blank padded at end
// - Send lesser of allocation and 106; zero sends none
// - Runs regardless of media, reservation, attention
module inq_responder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Decoded command from the target logic
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_vital_data_select,
  input  wire logic [2:0]  cmd_lun,
  input  wire logic [2:0]  ident_lun,
  input  wire logic [7:0]  cmd_alloc_len,
  // Data In byte stream
  output logic             din_valid,
  output logic [7:0]       din_byte,
  output logic             din_last,
  input  wire logic        din_ready,
  // Completion
  output logic             vpd_request,
  output logic             cmd_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  inq_pkg::state_t st_q;
  logic [6:0]      idx_q;
  logic [6:0]      idx_d;
  logic [7:0]      len_q;
  logic [7:0]      len_d;
  logic            lun_bad_q;
  logic            lun_bad_d;
  logic [7:0]      out_byte_q;
  logic            out_valid_q;
  logic            done_q;
  logic            vpd_q;
  logic [7:0]      sent_q;
  logic [15:0]     xfer_cnt_q;
  logic            custom_q;
  logic [31:0]     cfg_q [inq_pkg::CFG_WORDS];
  logic            bvalid_q;
  logic [1:0]      bresp_q;
  logic            rvalid_q;
  logic [1:0]      rresp_q;
  logic [31:0]     rdata_q;
  logic [4:0]      wslot;
  logic [4:0]      rslot;
  logic [31:0]     status_w;
  logic            accept;
  logic            fire;
  logic            last_beat;
  logic            wr_go;
  logic            rd_go;

  // Decode a storage word address into {hit, index}
  function automatic logic [4:0] cfg_slot(input logic [7:0] a);
    logic [7:0] off;
    off = 8'(a - inq_pkg::ADDR_CFG);
    if (a >= inq_pkg::ADDR_CFG && off[1:0] == 2'b00 &&
        off[7:2] < 6'(inq_pkg::CFG_WORDS)) begin
      return {1'b1, off[5:2]};
    end
    return 5'h00;
  endfunction

  // Byte-lane merge honouring write strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Handshakes; acceptance ignores media, reservation and attention
  assign cmd_ready = (st_q == inq_pkg::ST_IDLE);
  assign accept    = cmd_valid & cmd_ready;
  assign fire      = out_valid_q & din_ready;
  assign last_beat = (8'({1'b0, idx_q}) + 8'h01) == len_q;

  // Lesser of allocation and available bytes
  assign len_d = (cmd_alloc_len > inq_pkg::RESP_LEN_B) ?
                 inq_pkg::RESP_LEN_B : cmd_alloc_len;
  assign lun_bad_d = (|cmd_lun) | (|ident_lun);

  // Next index fed to the lookup so the byte register matches idx_q in the same cycle
  always_comb begin
    if (accept) begin
      idx_d = 7'h00;
    end else if (fire) begin
      idx_d = 7'(idx_q + 7'h01);
    end else begin
      idx_d = idx_q;
    end
  end

  // Byte table wiring; identity text comes from storage
  cfg_if cfg ();
  assign cfg.words     = cfg_q;
  assign cfg.custom_en = custom_q;
  assign cfg.lun_bad   = accept ? lun_bad_d : lun_bad_q;
  assign cfg.index     = idx_d;

  inq_byte_table u_table (
    .tbl (cfg.lookup)
  );

  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q        <= inq_pkg::ST_IDLE;
      out_valid_q <= 1'b0;
      done_q      <= 1'b0;
      vpd_q       <= 1'b0;
    end else begin
      done_q <= 1'b0;
      vpd_q  <= 1'b0;
      case (st_q)
        inq_pkg::ST_IDLE: begin
          if (accept && cmd_vital_data_select) begin
            vpd_q <= 1'b1;
          end else if (accept && len_d == 8'h00) begin
            st_q   <= inq_pkg::ST_DONE;
            done_q <= 1'b1;
          end else if (accept) begin
            st_q        <= inq_pkg::ST_SEND;
            out_valid_q <= 1'b1;
          end
        end
        inq_pkg::ST_SEND: begin
          if (fire && last_beat) begin
            st_q        <= inq_pkg::ST_DONE;
            out_valid_q <= 1'b0;
            done_q      <= 1'b1;
          end
        end
        inq_pkg::ST_DONE: begin
          st_q <= inq_pkg::ST_IDLE;
        end
        default: begin
          st_q        <= inq_pkg::ST_IDLE;
          out_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Index, length and unit latch for the transfer under way
  always_ff @(posedge clk) begin
    if (srst) begin
      idx_q     <= 7'h00;
      len_q     <= 8'h00;
      lun_bad_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      if (accept) begin
        len_q     <= len_d;
        lun_bad_q <= lun_bad_d;
      end
    end
  end

  // Outgoing byte register, reloaded from the lookup every cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      out_byte_q <= 8'h00;
    end else begin
      out_byte_q <= cfg.data;
    end
  end

  // Counters shown in the status word
  always_ff @(posedge clk) begin
    if (srst) begin
      sent_q     <= 8'h00;
      xfer_cnt_q <= 16'h0000;
    end else begin
      if (accept) begin
        sent_q <= 8'h00;
      end else if (fire) begin
        sent_q <= 8'(sent_q + 8'h01);
      end
      if (done_q) begin
        xfer_cnt_q <= 16'(xfer_cnt_q + 16'h0001);
      end
    end
  end

  assign din_valid   = out_valid_q;
  assign din_byte    = out_byte_q;
  assign din_last    = out_valid_q & last_beat;
  assign vpd_request = vpd_q;
  assign cmd_done    = done_q;

  // Status: transfer count, bytes of last transfer, unit flag, busy
  assign status_w = {xfer_cnt_q, sent_q, 6'h00, lun_bad_q,
                     (st_q != inq_pkg::ST_IDLE)};

  // Write path: address and data are taken together
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_wready  = s_axi_awready;
  assign wr_go         = s_axi_awready;
  assign wslot         = cfg_slot(s_axi_awaddr);

  // Write response; status is read only and silently ignores writes
  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= inq_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      if (wslot[4] || s_axi_awaddr == inq_pkg::ADDR_CTRL ||
          s_axi_awaddr == inq_pkg::ADDR_STATUS) begin
        bresp_q <= inq_pkg::RESP_OKAY;
      end else begin
        bresp_q <= inq_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register: enables the customer vendor-specific string
  always_ff @(posedge clk) begin
    if (srst) begin
      custom_q <= inq_pkg::CTRL_RST;
    end else if (wr_go && s_axi_awaddr == inq_pkg::ADDR_CTRL &&
                 s_axi_wstrb[0]) begin
      custom_q <= s_axi_wdata[0];
    end
  end

  // Identity storage words; reset to blanks so unset text pads cleanly
  for (genvar g = 0; g < inq_pkg::CFG_WORDS; g++) begin : g_cfg
    always_ff @(posedge clk) begin
      if (srst) begin
        cfg_q[g] <= inq_pkg::CFG_RST;
      end else if (wr_go && wslot == {1'b1, 4'(g)}) begin
        cfg_q[g] <= merge(cfg_q[g], s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Read path: one outstanding read, answer one cycle after acceptance
  assign s_axi_arready = ~rvalid_q;
  assign rd_go         = s_axi_arvalid & s_axi_arready;
  assign rslot         = cfg_slot(s_axi_araddr);

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= inq_pkg::RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= inq_pkg::RESP_OKAY;
      rdata_q  <= 32'h00000000;
      if (s_axi_araddr == inq_pkg::ADDR_STATUS) begin
        rdata_q <= status_w;
      end else if (s_axi_araddr == inq_pkg::ADDR_CTRL) begin
        rdata_q <= {31'h00000000, custom_q};
      end else if (rslot[4]) begin
        rdata_q <= cfg_q[rslot[3:0]];
      end else begin
        rresp_q <= inq_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // Checker helpers: beats and allocation seen since the last start
  logic [7:0] chk_beats_q;
  logic [7:0] chk_alloc_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      chk_beats_q <= 8'h00;
      chk_alloc_q <= 8'h00;
    end else if (accept) begin
      chk_beats_q <= 8'h00;
      chk_alloc_q <= cmd_alloc_len;
    end else if (fire) begin
      chk_beats_q <= 8'(chk_beats_q + 8'h01);
    end
  end

  sequence std_start_s;
    accept && !cmd_vital_data_select;
  endsequence

  sequence head_beat_s(logic [6:0] n);
    out_valid_q && idx_q == n;
  endsequence

  vpd_pass_a: assert property (
    accept && cmd_vital_data_select |=> vpd_q && !out_valid_q ##1 !vpd_q)
    else $error("vital data request not passed on");
  std_send_a: assert property (
    std_start_s ##0 cmd_alloc_len != 8'h00 |=> out_valid_q && idx_q == 0)
    else $error("standard response did not start");
  qualifier_a: assert property (
    head_beat_s(7'h00) ##0 !lun_bad_q |-> out_byte_q[7:5] == 3'h0)
    else $error("qualifier not zero");
  dev_type_a: assert property (
    head_beat_s(7'h00) ##0 !lun_bad_q |-> out_byte_q[4:0] == 5'h01)
    else $error("device type not 01h");
  lun_bad_a: assert property (
    std_start_s ##0 (|cmd_lun || |ident_lun) ##0 cmd_alloc_len != 0
    |=> out_byte_q == 8'h7f)
    else $error("invalid unit not flagged 7Fh");
  rmb_bit_a: assert property (
    head_beat_s(7'h01) |-> out_byte_q[7])
    else $error("removable flag clear");
  modifier_a: assert property (
    head_beat_s(7'h01) |-> out_byte_q[6:0] == 7'h00)
    else $error("type modifier not zero");
  version_a: assert property (
    head_beat_s(7'h02) |-> out_byte_q == 8'h02)
    else $error("version byte wrong");
  format_a: assert property (
    head_beat_s(7'h03) |-> out_byte_q == 8'h02)
    else $error("format byte wrong");
  add_len_a: assert property (
    head_beat_s(7'h04) |-> out_byte_q == 8'h65)
    else $error("additional length wrong");
  caps_byte_a: assert property (
    head_beat_s(7'h07) |-> out_byte_q == 8'h10)
    else $error("capability byte wrong");
  vspec_blank_a: assert property (
    out_valid_q && !custom_q && idx_q >= 36 && idx_q <= 55
    |-> out_byte_q == 8'h20)
    else $error("vendor-specific not blank");
  serial_pad_a: assert property (
    out_valid_q && idx_q >= 96 |-> out_byte_q != 8'h00)
    else $error("serial not padded");
  reserved_a: assert property (
    out_valid_q && (idx_q == 5 || idx_q == 6 ||
    (idx_q >= 56 && idx_q <= 95)) |-> out_byte_q == 8'h00)
    else $error("reserved byte not zero");
  zero_alloc_a: assert property (
    std_start_s ##0 cmd_alloc_len == 8'h00
    |=> done_q && !out_valid_q ##1 !done_q && !out_valid_q)
    else $error("zero allocation moved data");
  length_a: assert property (
    st_q == inq_pkg::ST_SEND ##1 done_q |-> chk_beats_q ==
    ((chk_alloc_q > 8'h6a) ? 8'h6a : chk_alloc_q))
    else $error("transfer length wrong");
endmodule // inq_responder

// *** tb/host_model.sv ***
// Behavioural initiator that issues commands and takes Data In bytes
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       clk,
  // Command side
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic            vsel,
  output logic [2:0]      lun,
  output logic [2:0]      ilun,
  output logic [7:0]      alloc,
  // Data In side
  input  wire logic       din_valid,
  input  wire logic [7:0] din_byte,
  input  wire logic       din_last,
  output logic            din_ready,
  // Completion pulses
  input  wire logic       vpd_request,
  input  wire logic       cmd_done
);
  logic       slow = 1'b0;
  logic [7:0] rx [$];
  int         last_at = -1;
  int         done_n = 0;
  int         vpd_n = 0;

  // Idle command fields at time zero
  initial begin
    cmd_valid = 1'b0;
    {vsel, lun, ilun, alloc} = '0;
    din_ready = 1'b1;
  end

  // Capture bytes; a slow host drops ready every other cycle
  always @(posedge clk) begin
    if (din_valid && din_ready) begin
      if (din_last) last_at = rx.size();
      rx.push_back(din_byte);
    end
    if (cmd_done) done_n++;
    if (vpd_request) vpd_n++;
    din_ready <= slow ? ~din_ready : 1'b1;
  end

  // Hold the command until taken, then scramble the released fields
  task automatic issue(input logic v, input logic [2:0] l, il,
                       input logic [7:0] a);
    @(posedge clk);
    cmd_valid <= 1'b1;
    {vsel, lun, ilun, alloc} <= {v, l, il, a};
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (cmd_ready) break;
    end
    cmd_valid <= 1'b0;
    {vsel, lun, ilun, alloc} <= ~{v, l, il, a};
  endtask
endmodule // host_model

// *** tb/tb_scsi_standard_inquiry_responder.sv ***
// Self-checking bench for the standard identification responder
`timescale 1ns/1ns
module tb_scsi_standard_inquiry_responder;
  logic clk = 1'b0, srst = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmd_valid, cmd_ready, vsel, din_valid, din_last;
  logic din_ready, vpd_request, cmd_done;
  logic [2:0] lun, ilun;
  logic [7:0] alloc, din_byte;
  logic [31:0] cfg [15];
  logic [31:0] rd;
  logic [1:0] rs;
  int fails = 0, tests_run = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  inq_responder i_dut (
    .clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_vital_data_select(vsel), .cmd_lun(lun), .ident_lun(ilun),
    .cmd_alloc_len(alloc), .din_valid(din_valid), .din_byte(din_byte),
    .din_last(din_last), .din_ready(din_ready),
    .vpd_request(vpd_request), .cmd_done(cmd_done));

  host_model i_host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .vsel(vsel), .lun(lun), .ilun(ilun), .alloc(alloc),
    .din_valid(din_valid), .din_byte(din_byte), .din_last(din_last),
    .din_ready(din_ready), .vpd_request(vpd_request),
    .cmd_done(cmd_done));

  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // A wait that runs out counts as a mismatch and ends the run
  task automatic hang();
    fails++;
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int k;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // Ready is judged only at an edge, after the request has landed
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_awready) break;
    end
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    if (k == 50) hang();
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) hang();
  endtask

  // Read: rready held until rvalid, data taken at that edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    // Ready is idle-high, so wait for the edge that takes the request
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_arready) break;
    end
    s_axi_arvalid <= 1'b0;
    if (k == 50) hang();
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_rvalid) break;
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (k == 50) hang();
  endtask

  // Expected response byte worked out from the field layout
  function automatic logic [7:0] exp_byte(int p, logic bad, logic cus);
    logic [7:0] hdr [8];
    logic [7:0] b;
    hdr = '{8'h01, 8'h80, 8'h02, 8'h02, 8'h65, 8'h00, 8'h00, 8'h10};
    b = (p < 8) ? 8'h00 :
        cfg[(p < 96) ? (p - 8) / 4 : (p - 48) / 4][(p % 4) * 8 +: 8];
    if (p == 0) return bad ? 8'h7f : 8'h01;
    if (p < 8) return hdr[p];
    if (p < 36) return b;
    if (p < 56) return cus ? b : 8'h20;
    if (p < 96) return 8'h00;
    return (b == 8'h00) ? 8'h20 : b;
  endfunction

  // One command through the host model, then the whole reply judged
  task automatic xfer(input logic v, input logic [2:0] l, il,
                      input logic [7:0] a, input logic s, cus, input int n);
    int d0, v0, k;
    d0 = i_host.done_n;
    v0 = i_host.vpd_n;
    i_host.rx.delete();
    i_host.last_at = -1;
    i_host.slow = s;
    i_host.issue(v, l, il, a);
    for (k = 0; k < 600 && i_host.done_n == d0 && i_host.vpd_n == v0; k++)
      @(posedge clk);
    if (k == 600) hang();
    repeat (3) @(posedge clk);
    chk(i_host.rx.size(), n);
    chk(i_host.last_at, n - 1);
    chk(i_host.done_n - d0, {31'h0, ~v});
    chk(i_host.vpd_n - v0, {31'h0, v});
    for (k = 0; k < n; k++)
      chk(i_host.rx[k], exp_byte(k, (l != 0) || (il != 0), cus));
  endtask

  // Reset values, unmapped access, then identity storage loaded
  task automatic t_regs();
    axi_rd(inq_pkg::ADDR_CTRL, rd, rs);
    chk(rd, 32'h0);
    axi_rd(inq_pkg::ADDR_CFG + 8'h0c, rd, rs);
    chk(rd, inq_pkg::CFG_RST);
    axi_rd(8'hfc, rd, rs);
    chk(rs, inq_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(8'hfc, 32'h0, rs);
    chk(rs, inq_pkg::RESP_SLVERR);
    for (int i = 0; i < 15; i++) begin
      for (int j = 0; j < 4; j++) cfg[i][j * 8 +: 8] = 8'h41 + 8'(4 * i + j);
      if (i == 14) cfg[i][15:8] = 8'h00;
      axi_wr(inq_pkg::ADDR_CFG + 8'(4 * i), cfg[i], rs);
      chk(rs, inq_pkg::RESP_OKAY);
    end
    axi_rd(inq_pkg::ADDR_CFG + 8'h38, rd, rs);
    chk(rd, cfg[14]);
  endtask

  // Allocation above 106 with a prompt host: whole table, blanks in 36-55
  // Customer string is switched off first, since an earlier run may set it
  task automatic t_full();
    axi_wr(inq_pkg::ADDR_CTRL, 32'h0, rs);
    chk(rs, inq_pkg::RESP_OKAY);
    xfer(1'b0, 3'h0, 3'h0, 8'hff, 1'b0, 1'b0, 106);
  endtask

  // Customer string on, bad unit in the command, stalling host
  task automatic t_custom();
    axi_wr(inq_pkg::ADDR_CTRL, 32'h1, rs);
    chk(rs, inq_pkg::RESP_OKAY);
    xfer(1'b0, 3'h3, 3'h0, 8'h6a, 1'b1, 1'b1, 106);
    // Two transfers done, 106 bytes in the last, bad unit latched, idle
    axi_rd(inq_pkg::ADDR_STATUS, rd, rs);
    chk(rd, 32'h00026a02);
  endtask

  // Bad unit from the Identify message, only byte 0 asked for
  task automatic t_ident();
    xfer(1'b0, 3'h0, 3'h5, 8'h01, 1'b0, 1'b1, 1);
  endtask

  // One byte short of the table while stalling
  task automatic t_short();
    xfer(1'b0, 3'h0, 3'h0, 8'h69, 1'b1, 1'b1, 105);
  endtask

  // Zero allocation ends cleanly with no data
  task automatic t_zero();
    xfer(1'b0, 3'h0, 3'h0, 8'h00, 1'b0, 1'b1, 0);
  endtask

  // Page request: handed out, no standard data sent
  task automatic t_vpd();
    xfer(1'b1, 3'h0, 3'h0, 8'h06, 1'b0, 1'b1, 0);
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_full();
    t_custom();
    t_ident();
    t_short();
    t_zero();
    t_vpd();
    t_full();
    give_verdict();
  end
endmodule // tb_scsi_standard_inquiry_responder
